// file: src/sbs_core.sv
// How it works
// - Both fields zero: divide clock by two
// - Each select step doubles the divisor
// - Preselect multiplies divisor by value plus one
// - Divider runs only as master mid-transfer
// - Auto select low in transfer, high idle
// - Auto select needs master, enable, fault enable
// - No mode faults while auto select active
// - Single pin bit selects bidirectional mode
// - Bidirectional: master uses MOSI, slave MISO
// - Bidirectional: other data pin left unused
module sbs_core (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic                        spi_enable,
    input  wire logic                        master_role_bit,
    input  wire logic                        single_pin_mode_bit,
    input  wire logic                        shared_pin_out_enable,
    input  wire logic                        select_output_enable,
    input  wire logic                        fault_detect_enable,
    input  wire logic [sbs_pkg::SEL_W-1:0]   rate_select_field,
    input  wire logic [sbs_pkg::SEL_W-1:0]   rate_preselect_field,
    input  wire logic                        mode_fault_clear,
    input  wire logic [sbs_pkg::DATA_W-1:0]  tx_data,
    input  wire logic                        tx_valid,
    output      logic                        tx_ready,
    output      logic [sbs_pkg::DATA_W-1:0]  rx_data,
    output      logic                        rx_valid,
    output      logic                        busy,
    output      logic                        mode_fault,
    output      logic                        sclk_o,
    output      logic                        sclk_oe,
    input  wire logic                        sclk_i,
    output      logic                        mosi_o,
    output      logic                        mosi_oe,
    input  wire logic                        mosi_i,
    output      logic                        miso_o,
    output      logic                        miso_oe,
    input  wire logic                        miso_i,
    output      logic                        ss_n_o,
    output      logic                        ss_n_oe,
    input  wire logic                        ss_n_i
);

    // ------------------------------------------------------------
    // Transmit buffer
    // ------------------------------------------------------------
    sbs_stream_if #(.W(sbs_pkg::DATA_W)) wr_if ();
    sbs_stream_if #(.W(sbs_pkg::DATA_W)) rd_if ();

    assign wr_if.data  = tx_data;
    assign wr_if.valid = tx_valid;
    assign tx_ready    = wr_if.ready;

    sbs_fifo #(
        .W     (sbs_pkg::DATA_W),
        .DEPTH (sbs_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wr      (wr_if.snk),
        .rd      (rd_if.src)
    );

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Pins are asynchronous; only the second stage is ever read
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic       sclk_prev_reg;
    logic       ss_prev_reg;
    logic       sclk_s;
    logic       mosi_s;
    logic       miso_s;
    logic       ss_s;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_meta_reg  <= {sbs_pkg::SS_IDLE_LVL, 2'b00, sbs_pkg::SCLK_IDLE};
            pin_sync_reg  <= {sbs_pkg::SS_IDLE_LVL, 2'b00, sbs_pkg::SCLK_IDLE};
            sclk_prev_reg <= sbs_pkg::SCLK_IDLE;
            ss_prev_reg   <= sbs_pkg::SS_IDLE_LVL;
        end else begin
            pin_meta_reg  <= {ss_n_i, miso_i, mosi_i, sclk_i};
            pin_sync_reg  <= pin_meta_reg;
            sclk_prev_reg <= pin_sync_reg[0];
            ss_prev_reg   <= pin_sync_reg[3];
        end
    end

    assign sclk_s = pin_sync_reg[0];
    assign mosi_s = pin_sync_reg[1];
    assign miso_s = pin_sync_reg[2];
    assign ss_s   = pin_sync_reg[3];

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    logic auto_select;
    logic data_in;
    logic slave_rise;
    logic slave_fall;
    logic slave_start;

    assign auto_select = spi_enable && master_role_bit
                         && select_output_enable && fault_detect_enable;

    always_comb begin
        if (master_role_bit) begin
            data_in = single_pin_mode_bit ? mosi_s : miso_s;
        end else begin
            data_in = single_pin_mode_bit ? miso_s : mosi_s;
        end
    end

    assign slave_rise  = sclk_s && !sclk_prev_reg;
    assign slave_fall  = !sclk_s && sclk_prev_reg;
    assign slave_start = !ss_s && ss_prev_reg;

    // ------------------------------------------------------------
    // Baud rate divider
    // ------------------------------------------------------------
    // Half period is (pre+1) << sel, so a full period is twice that
    sbs_pkg::sbs_state_e        state_reg;
    logic [sbs_pkg::HALF_W-1:0] half_len;
    logic [sbs_pkg::HALF_W-1:0] div_cnt_reg;
    logic                       div_run;
    logic                       baud_tick;

    function automatic logic [sbs_pkg::HALF_W-1:0] HALF_W_ZERO_EXT(
        input logic [sbs_pkg::SEL_W-1:0] v
    );
        HALF_W_ZERO_EXT = {{(sbs_pkg::HALF_W-sbs_pkg::SEL_W){1'b0}}, v};
    endfunction : HALF_W_ZERO_EXT

    assign half_len = (HALF_W_ZERO_EXT(rate_preselect_field) + sbs_pkg::HALF_ONE)
                      << rate_select_field;
    assign div_run   = (state_reg == sbs_pkg::SBS_MASTER);
    assign baud_tick = div_run && (div_cnt_reg == half_len - sbs_pkg::HALF_ONE);

    // Held at zero when idle so the divider draws no switching power
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_cnt_reg <= sbs_pkg::HALF_RST;
        end else if (!div_run || baud_tick) begin
            div_cnt_reg <= sbs_pkg::HALF_RST;
        end else begin
            div_cnt_reg <= div_cnt_reg + sbs_pkg::HALF_ONE;
        end
    end

    // ------------------------------------------------------------
    // Transfer engine
    // ------------------------------------------------------------
    logic                        master_load;
    logic                        slave_load;
    logic                        sample_now;
    logic                        shift_now;
    logic [sbs_pkg::BIT_W-1:0]   bit_cnt_reg;
    logic [sbs_pkg::DATA_W-1:0]  tx_shift_reg;
    logic [sbs_pkg::DATA_W-1:0]  rx_shift_reg;
    logic                        sclk_reg;

    assign master_load = (state_reg == sbs_pkg::SBS_IDLE) && spi_enable
                         && master_role_bit && rd_if.valid;
    assign slave_load  = spi_enable && !master_role_bit && rd_if.valid
                         && ((state_reg == sbs_pkg::SBS_IDLE && slave_start)
                         || (state_reg == sbs_pkg::SBS_SLAVE && slave_fall
                         && bit_cnt_reg == sbs_pkg::LAST_BIT));
    assign rd_if.ready = master_load || slave_load;

    assign sample_now = (state_reg == sbs_pkg::SBS_MASTER) ? (baud_tick && !sclk_reg)
                        : (state_reg == sbs_pkg::SBS_SLAVE && slave_rise);
    assign shift_now  = (state_reg == sbs_pkg::SBS_MASTER) ? (baud_tick && sclk_reg)
                        : (state_reg == sbs_pkg::SBS_SLAVE && slave_fall);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= sbs_pkg::SBS_IDLE;
        end else begin
            unique case (state_reg)
                sbs_pkg::SBS_IDLE: begin
                    if (master_load) begin
                        state_reg <= sbs_pkg::SBS_MASTER;
                    end else if (spi_enable && !master_role_bit && slave_start) begin
                        state_reg <= sbs_pkg::SBS_SLAVE;
                    end
                end
                sbs_pkg::SBS_MASTER: begin
                    if (!spi_enable || !master_role_bit) begin
                        state_reg <= sbs_pkg::SBS_IDLE;
                    end else if (shift_now && bit_cnt_reg == sbs_pkg::LAST_BIT) begin
                        state_reg <= sbs_pkg::SBS_IDLE;
                    end
                end
                sbs_pkg::SBS_SLAVE: begin
                    if (ss_s || !spi_enable || master_role_bit) begin
                        state_reg <= sbs_pkg::SBS_IDLE;
                    end
                end
            endcase
        end
    end

    // Mode 0, MSB first: sample on the rising edge, shift on falling
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_shift_reg <= sbs_pkg::SHIFT_RST;
            rx_shift_reg <= sbs_pkg::SHIFT_RST;
            bit_cnt_reg  <= sbs_pkg::BIT_RST;
            sclk_reg     <= sbs_pkg::SCLK_IDLE;
        end else begin
            if (rd_if.ready) begin
                tx_shift_reg <= rd_if.data;
            end else if (shift_now) begin
                tx_shift_reg <= {tx_shift_reg[sbs_pkg::DATA_W-2:0], 1'b0};
            end
            if (sample_now) begin
                rx_shift_reg <= {rx_shift_reg[sbs_pkg::DATA_W-2:0], data_in};
            end
            if (state_reg == sbs_pkg::SBS_IDLE) begin
                bit_cnt_reg <= sbs_pkg::BIT_RST;
            end else if (shift_now) begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
            if (state_reg != sbs_pkg::SBS_MASTER) begin
                sclk_reg <= sbs_pkg::SCLK_IDLE;
            end else if (baud_tick) begin
                sclk_reg <= !sclk_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Received byte and status
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_data  <= sbs_pkg::SHIFT_RST;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= sample_now && (bit_cnt_reg == sbs_pkg::LAST_BIT);
            if (sample_now && bit_cnt_reg == sbs_pkg::LAST_BIT) begin
                rx_data <= {rx_shift_reg[sbs_pkg::DATA_W-2:0], data_in};
            end
        end
    end

    // Sticky; a fault in the clearing cycle still lands
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode_fault <= 1'b0;
        end else if (spi_enable && master_role_bit && fault_detect_enable
                     && !select_output_enable && !ss_s) begin
            mode_fault <= 1'b1;
        end else if (mode_fault_clear) begin
            mode_fault <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_reg != sbs_pkg::SBS_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // Enables lag the control bits by one cycle so all come from flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sclk_oe <= 1'b0;
            mosi_oe <= 1'b0;
            miso_oe <= 1'b0;
            ss_n_oe <= 1'b0;
            ss_n_o  <= sbs_pkg::SS_IDLE_LVL;
        end else begin
            sclk_oe <= spi_enable && master_role_bit;
            mosi_oe <= spi_enable && master_role_bit
                       && (!single_pin_mode_bit || shared_pin_out_enable);
            miso_oe <= spi_enable && !master_role_bit && !ss_s
                       && (!single_pin_mode_bit || shared_pin_out_enable);
            ss_n_oe <= auto_select;
            ss_n_o  <= !(auto_select && state_reg == sbs_pkg::SBS_MASTER);
        end
    end

    assign sclk_o = sclk_reg;
    assign mosi_o = tx_shift_reg[sbs_pkg::DATA_W-1];
    assign miso_o = tx_shift_reg[sbs_pkg::DATA_W-1];

endmodule : sbs_core

// file: pkg/sbs_pkg.sv
package sbs_pkg;

    // ------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------
    localparam int DATA_W     = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int SEL_W      = 3;
    localparam int HALF_W     = 11;
    localparam int BIT_W      = 3;

    // ------------------------------------------------------------
    // Counts and reset values
    // ------------------------------------------------------------
    localparam logic [BIT_W-1:0]  LAST_BIT    = 3'h7;
    localparam logic [HALF_W-1:0] HALF_ONE    = 11'h001;
    localparam logic [HALF_W-1:0] HALF_RST    = 11'h000;
    localparam logic [BIT_W-1:0]  BIT_RST     = 3'h0;
    localparam logic [DATA_W-1:0] SHIFT_RST   = 8'h00;
    localparam logic              SS_IDLE_LVL = 1'b1;
    localparam logic              SCLK_IDLE   = 1'b0;

    // ------------------------------------------------------------
    // Transfer engine states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SBS_IDLE,
        SBS_MASTER,
        SBS_SLAVE
    } sbs_state_e;

endpackage : sbs_pkg

// file: pkg/sbs_stream_if.sv
interface sbs_stream_if #(
    parameter int W = 8
);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : sbs_stream_if

// file: src/sbs_fifo.sv
module sbs_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic   sys_clk,
    input  wire logic   rst,
    sbs_stream_if.snk   wr,
    sbs_stream_if.src   rd
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0]   count_reg;
    logic [AW:0]   count_next;
    logic          push;
    logic          pop;

    // ------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------
    // Ready and valid come from flops so both sides see clean levels
    assign push = wr.valid && wr.ready;
    assign pop  = rd.valid && rd.ready;

    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + (AW+1)'(1);
        end else if (pop && !push) begin
            count_next = count_reg - (AW+1)'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
            wr.ready  <= 1'b1;
            rd.valid  <= 1'b0;
        end else begin
            count_reg <= count_next;
            wr.ready  <= (count_next != (AW+1)'(DEPTH));
            rd.valid  <= (count_next != '0);
        end
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + AW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= wr.data;
        end
    end

    assign rd.data = mem[rd_ptr_reg];

endmodule : sbs_fifo

// file: dv/sbs_core_assertions.sv
module sbs_core_assertions (
    input logic       sys_clk,
    input logic       rst,
    input logic       spi_enable,
    input logic       master_role_bit,
    input logic       single_pin_mode_bit,
    input logic       shared_pin_out_enable,
    input logic       select_output_enable,
    input logic       fault_detect_enable,
    input logic [2:0] rate_select_field,
    input logic [2:0] rate_preselect_field,
    input logic       busy,
    input logic       mode_fault,
    input logic       sclk_o,
    input logic       sclk_oe,
    input logic       mosi_oe,
    input logic       miso_oe,
    input logic       ss_n_o,
    input logic       ss_n_oe,
    input logic       ss_n_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // --------
    // Helper logic
    // --------
    logic [10:0] half;
    logic [10:0] hi_cnt;

    // Fields must stay put for a whole byte, else the count is meaningless
    assign half = (11'(rate_preselect_field) + 11'h001) << rate_select_field;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) hi_cnt <= 11'h000;
        else if (sclk_o) hi_cnt <= hi_cnt + 11'h001;
        else hi_cnt <= 11'h000;
    end

    // --------
    // Assertions
    // --------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_half_period: assert property (
        $fell(sclk_o) |-> hi_cnt == half) else $error("serial clock high phase wrong");
    chk_sclk_idle: assert property (
        !busy |-> !sclk_o) else $error("serial clock moves while idle");
    chk_sclk_role: assert property (
        !$past(rst) && !$past(master_role_bit) |-> !sclk_oe) else $error("slave drives clock");
    chk_ss_low_busy: assert property (
        !ss_n_o |-> busy) else $error("select low while idle");
    chk_ss_low_run: assert property (
        busy && spi_enable && master_role_bit && select_output_enable && fault_detect_enable
        |-> !ss_n_o) else $error("select high during transfer");
    chk_ss_oe_auto: assert property (
        !$past(rst) |-> ss_n_oe == $past(spi_enable && master_role_bit
        && select_output_enable && fault_detect_enable)) else $error("select enable wrong");
    chk_no_fault_auto: assert property (
        $rose(mode_fault) |-> !$past(select_output_enable && fault_detect_enable
        && master_role_bit)) else $error("fault raised under auto select");
    chk_bidir_master: assert property (
        !$past(rst) && $past(single_pin_mode_bit && master_role_bit && spi_enable)
        |-> !miso_oe && mosi_oe == $past(shared_pin_out_enable)) else $error("master pins");
    chk_bidir_slave: assert property (
        !$past(rst) && $past(single_pin_mode_bit && !master_role_bit && spi_enable)
        |-> !mosi_oe && miso_oe == ($past(shared_pin_out_enable) && !$past(ss_n_i, 3)))
        else $error("slave pins");
    chk_two_pin: assert property (
        !$past(rst) && $past(!single_pin_mode_bit && master_role_bit && spi_enable)
        |-> mosi_oe && !miso_oe) else $error("normal master pins");
endmodule : sbs_core_assertions

bind sbs_core sbs_core_assertions i_chk (
    .sys_clk(sys_clk), .rst(rst), .spi_enable(spi_enable), .master_role_bit(master_role_bit),
    .single_pin_mode_bit(single_pin_mode_bit), .shared_pin_out_enable(shared_pin_out_enable),
    .select_output_enable(select_output_enable), .fault_detect_enable(fault_detect_enable),
    .rate_select_field(rate_select_field), .rate_preselect_field(rate_preselect_field),
    .busy(busy), .mode_fault(mode_fault), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
    .mosi_oe(mosi_oe), .miso_oe(miso_oe), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .ss_n_i(ss_n_i)
);

// file: dv/sbs_spi_partner.sv
module sbs_spi_partner (
    input  logic       sclk,
    input  logic       ss_n,
    input  logic       mosi,
    input  logic [7:0] reply,
    output logic       miso,
    output logic [7:0] got
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] sh;

    initial begin
        miso = 1'b0;
        got = 8'h00;
    end
    // Released line shows the inverse of its last level, never a held value
    always @(ss_n) begin
        if (!ss_n) begin
            sh = reply;
            miso = reply[7];
        end else miso = ~miso;
    end
    always @(posedge sclk) if (!ss_n) got = {got[6:0], mosi};
    always @(negedge sclk) begin
        if (!ss_n) begin
            sh = {sh[6:0], 1'b0};
            miso = sh[7];
        end
    end
endmodule : sbs_spi_partner

// file: dv/spi_baud_ss_bidir_tb.sv
module spi_baud_ss_bidir_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // --------
    // Signals
    // --------
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic spi_enable, master_role_bit, single_pin_mode_bit, shared_pin_out_enable;
    logic select_output_enable, fault_detect_enable, mode_fault_clear, tx_valid;
    logic [2:0] rate_select_field, rate_preselect_field;
    logic [7:0] tx_data, rx_data, reply, got;
    logic tx_ready, rx_valid, busy, mode_fault, sclk_o, sclk_oe, sclk_i, mosi_o;
    logic mosi_oe, mosi_i, miso_o, miso_oe, miso_i, part_miso, ss_n_o, ss_n_oe, ss_n_i;
    logic [5:0] cfg [8] = '{6'h00, 6'h08, 6'h10, 6'h01, 6'h02, 6'h11, 6'h1C, 6'h3F};
    int bad_count = 0;
    int check_count = 0;

    always #5 sys_clk = ~sys_clk;
    assign miso_i = miso_oe ? miso_o : part_miso;
    assign mosi_i = mosi_oe ? mosi_o : 1'b1;
    assign sclk_i = 1'b0;

    sbs_core i_dut (
        .sys_clk(sys_clk), .rst(rst), .spi_enable(spi_enable),
        .master_role_bit(master_role_bit), .single_pin_mode_bit(single_pin_mode_bit),
        .shared_pin_out_enable(shared_pin_out_enable),
        .select_output_enable(select_output_enable), .fault_detect_enable(fault_detect_enable),
        .rate_select_field(rate_select_field), .rate_preselect_field(rate_preselect_field),
        .mode_fault_clear(mode_fault_clear), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy),
        .mode_fault(mode_fault), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .sclk_i(sclk_i),
        .mosi_o(mosi_o), .mosi_oe(mosi_oe), .mosi_i(mosi_i),
        .miso_o(miso_o), .miso_oe(miso_oe), .miso_i(miso_i),
        .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .ss_n_i(ss_n_i)
    );
    sbs_spi_partner i_slave (.sclk(sclk_o), .ss_n(ss_n_o), .mosi(mosi_o), .reply(reply),
                             .miso(part_miso), .got(got));

    // --------
    // Tasks
    // --------
    task automatic cmp(input logic [15:0] act, input logic [15:0] exp);
        check_count++;
        if (act !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : cmp

    task automatic end_of_test();
        if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick

    // One master byte; bounded waits since a dead divider would hang here
    task automatic xfer(input logic [2:0] s, input logic [2:0] p, input logic [7:0] d);
        int n;
        rate_select_field = s;
        rate_preselect_field = p;
        tx_data = d;
        reply = ~d;
        tx_valid = 1'b1;
        tick(1);
        tx_valid = 1'b0;
        n = 0;
        while (!sclk_o && n < 3000) begin tick(1); n++; end
        cmp({busy, ss_n_o}, 2'b10);
        n = 0;
        while (sclk_o && n < 3000) begin tick(1); n++; end
        while (!sclk_o && n < 3000) begin tick(1); n++; end
        cmp(n, (int'(p) + 1) << (s + 1));
        while (!rx_valid && n < 40000) begin tick(1); n++; end
        if (((int'(p) + 1) << s) >= 8) cmp(rx_data, reply);
        cmp(got, d);
        while (busy && n < 40000) begin tick(1); n++; end
        cmp({ss_n_o, sclk_o}, 2'b10);
    endtask : xfer

    // --------
    // Sequence
    // --------
    initial begin
        {spi_enable, master_role_bit, select_output_enable, fault_detect_enable} = 4'hF;
        {single_pin_mode_bit, shared_pin_out_enable, mode_fault_clear, tx_valid} = 4'h0;
        {rate_select_field, rate_preselect_field, tx_data, reply} = 22'h0;
        ss_n_i = 1'b1;
        repeat (16) @(posedge sys_clk);
        tick(1);
        rst = 1'b0;
        tick(2);
        cmp({tx_ready, busy, ss_n_o, sclk_o, mosi_oe, miso_oe}, 6'h2A);
        for (int i = 0; i < 8; i++) xfer(cfg[i][5:3], cfg[i][2:0], {cfg[i], 2'b01});
        ss_n_i = 1'b0;
        tick(8);
        cmp({mode_fault, ss_n_oe}, 2'b01);
        select_output_enable = 1'b0;
        tick(8);
        cmp({mode_fault, ss_n_oe}, 2'b10);
        {master_role_bit, select_output_enable, ss_n_i, mode_fault_clear} = 4'h7;
        tick(2);
        mode_fault_clear = 1'b0;
        tick(2);
        cmp({mode_fault, ss_n_oe}, 2'b00);
        single_pin_mode_bit = 1'b1;
        for (int i = 0; i < 4; i++) begin
            master_role_bit = i[1];
            shared_pin_out_enable = i[0];
            tick(2);
            cmp({mosi_oe, miso_oe}, {i[1] & i[0], 1'b0});
        end
        // A slave only drives the shared pin while it is selected
        {master_role_bit, shared_pin_out_enable, ss_n_i} = 3'h2;
        tick(4);
        cmp({mosi_oe, miso_oe}, 2'b01);
        end_of_test();
    end

    initial begin
        #400_000;
        bad_count++;
        end_of_test();
    end
endmodule : spi_baud_ss_bidir_tb
